// *** core/tsf_defines.svh ***
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

// ----------------------------------------------------------------
// buffer mode select codes
// ----------------------------------------------------------------
`define TSF_MODE_BYPASS 3'h0
`define TSF_MODE_STOP_FULL 3'h1
`define TSF_MODE_CONT_TO_STOP 3'h3
`define TSF_MODE_BYPASS_TO_CONT 3'h4
`define TSF_MODE_CONTINUOUS 3'h6
`define TSF_MODE_BYPASS_TO_STOP 3'h7

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define TSF_DEPTH 512
`define TSF_CNT_W 10
`define TSF_THR_W 9
`define TSF_WORD_BYTES 7
`define TSF_LAST_BYTE 3'h6
`define TSF_TAG_BYTE 3'h0
`define TSF_BUF_ENTRIES 2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TSF_RST_COUNT 10'h000
`define TSF_RST_BYTE 8'h00

`endif

// *** core/tsf_pkg.sv ***
package tsf_pkg;
  `include "tsf_defines.svh"

  typedef struct packed {
    logic [47:0] data;
    logic [7:0] tag;
  } tsf_sample_t;

  typedef struct packed {
    logic [`TSF_CNT_W-1:0] stored_word_count;
    logic threshold_reached_flag;
    logic buffer_full_flag;
    logic overrun_flag;
    logic overrun_sticky_flag;
  } tsf_status_t;

  typedef struct packed {
    logic route_freefall_to_irq_b;
    logic route_wakeup_to_irq_b;
    logic route_orientation_to_irq_b;
  } tsf_route_t;

  typedef enum logic [2:0] {
    TSF_PH_IDLE = 3'b001,
    TSF_PH_OVERWRITE = 3'b010,
    TSF_PH_STOP = 3'b100
  } tsf_phase_t;
endpackage

// *** core/tsf_triggered_fifo.sv ***
`timescale 1ns/1ps
// Functional notes
// - code 011: overwrite, then stop after trigger
// - trigger from routed freefall, wakeup, orientation
// - edge sensitive, held until bypass written
// - full flag when next write fills
// - stop bit limits depth to threshold
// - full at trigger: store nothing more
// - not full at trigger: fill, then stop
// - code 100: idle until trigger, then overwrite
// - code 111: idle until trigger, then stop-when-full
// - bypass-to-stop: full flag, cease storing
// - read returns oldest stored word
// - finished word frees slot, next oldest follows
// - ten-bit stored word count, zero empty
// - byte index wraps from last to tag
// - nine-bit threshold in whole words
// - threshold flag when count reaches threshold
// - stop bit clear: threshold never halts storing
// - stop bit set: threshold flag at full
// - limited continuous depth overwrites oldest first
// - code 000 clears and keeps empty
// - code 001 fills then holds contents
// - code 110 stores continuously, replacing oldest
// - instantaneous and sticky overrun flags
`include "tsf_defines.svh"
module tsf_triggered_fifo #(
  parameter int DEPTH = `TSF_DEPTH
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // configuration
  input wire logic [2:0] MODE_SELECT_I,
  input wire logic STOP_AT_THRESHOLD_I,
  input wire logic [`TSF_THR_W-1:0] THRESHOLD_LEVEL_I,
  input wire tsf_pkg::tsf_route_t IRQ_B_ROUTING_CONFIG_I,
  // event detectors
  input wire logic FREEFALL_EVENT_I,
  input wire logic WAKEUP_EVENT_I,
  input wire logic ORIENTATION_EVENT_I,
  // sample stream in
  input wire logic SAMPLE_VALID_I,
  input wire tsf_pkg::tsf_sample_t SAMPLE_I,
  output logic SAMPLE_READY_O,
  // host byte readout
  input wire logic BURST_START_I,
  input wire logic BYTE_READ_I,
  output logic [7:0] READ_BYTE_O,
  // status
  output tsf_pkg::tsf_status_t STATUS_O
);
  import tsf_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam logic [`TSF_CNT_W-1:0] DEPTH_CNT = `TSF_CNT_W'(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    tsf_phase_t phase;
    logic trig;
    logic evt_prev;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [`TSF_CNT_W-1:0] count;
    logic [2:0] byte_idx;
    logic [7:0] rd_byte;
    tsf_sample_t buf0;
    tsf_sample_t buf1;
    logic [1:0] buf_cnt;
    tsf_status_t status;
  } tsf_state_t;

  tsf_state_t s_q;
  tsf_state_t s_d;
  tsf_sample_t mem [DEPTH];

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  function automatic logic [`TSF_CNT_W-1:0] capacity(input logic stop, input logic [`TSF_THR_W-1:0] thr);
    // a threshold above the store depth must not let the count outrun the memory
    capacity = (stop && ({1'b0, thr} < DEPTH_CNT)) ? {1'b0, thr} : DEPTH_CNT;
  endfunction

  // ----------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------
  logic evt_now;
  logic evt_edge;
  logic armed;
  logic pop;
  logic drain;
  logic do_write;
  logic overwrite;
  logic [`TSF_CNT_W-1:0] cap;
  tsf_sample_t head;

  assign head = mem[s_q.rd_ptr];
  assign cap = capacity(STOP_AT_THRESHOLD_I, THRESHOLD_LEVEL_I);
  // a finished word and a new sample never touch the memory in one cycle
  assign pop = BYTE_READ_I && (s_q.byte_idx == `TSF_LAST_BYTE) && (s_q.count != '0)
               && (s_q.phase != TSF_PH_IDLE);
  assign drain = (s_q.buf_cnt != 2'h0) && !pop;
  assign SAMPLE_READY_O = (s_q.buf_cnt != `TSF_BUF_ENTRIES);

  always_comb begin
    s_d = s_q;
    evt_now = (FREEFALL_EVENT_I && IRQ_B_ROUTING_CONFIG_I.route_freefall_to_irq_b)
           || (WAKEUP_EVENT_I && IRQ_B_ROUTING_CONFIG_I.route_wakeup_to_irq_b)
           || (ORIENTATION_EVENT_I && IRQ_B_ROUTING_CONFIG_I.route_orientation_to_irq_b);
    evt_edge = evt_now && !s_q.evt_prev;
    armed = (MODE_SELECT_I == `TSF_MODE_CONT_TO_STOP) || (MODE_SELECT_I == `TSF_MODE_BYPASS_TO_CONT)
         || (MODE_SELECT_I == `TSF_MODE_BYPASS_TO_STOP);
    do_write = 1'b0;
    overwrite = 1'b0;
    s_d.evt_prev = evt_now;
    if (MODE_SELECT_I == `TSF_MODE_BYPASS) begin
      s_d.trig = 1'b0;
    end else if (armed && evt_edge) begin
      s_d.trig = 1'b1;
    end
    // phase follows mode and the held trigger
    case (MODE_SELECT_I)
      `TSF_MODE_STOP_FULL: s_d.phase = TSF_PH_STOP;
      `TSF_MODE_CONTINUOUS: s_d.phase = TSF_PH_OVERWRITE;
      `TSF_MODE_CONT_TO_STOP: s_d.phase = s_d.trig ? TSF_PH_STOP : TSF_PH_OVERWRITE;
      `TSF_MODE_BYPASS_TO_CONT: s_d.phase = s_d.trig ? TSF_PH_OVERWRITE : TSF_PH_IDLE;
      `TSF_MODE_BYPASS_TO_STOP: s_d.phase = s_d.trig ? TSF_PH_STOP : TSF_PH_IDLE;
      default: s_d.phase = TSF_PH_IDLE;
    endcase

    // readout: byte index walks tag..last and wraps
    if (BURST_START_I) begin
      s_d.byte_idx = `TSF_TAG_BYTE;
    end else if (BYTE_READ_I) begin
      s_d.rd_byte = head[s_q.byte_idx*8 +: 8];
      s_d.byte_idx = (s_q.byte_idx == `TSF_LAST_BYTE) ? `TSF_TAG_BYTE : s_q.byte_idx + 3'h1;
    end
    if (pop) begin
      s_d.rd_ptr = next_ptr(s_q.rd_ptr);
      s_d.count = s_q.count - `TSF_CNT_W'(1);
    end

    // storage decision for the oldest buffered sample
    if (drain) begin
      if (s_q.phase == TSF_PH_OVERWRITE) begin
        do_write = 1'b1;
        overwrite = (s_q.count >= cap);
      end else if (s_q.phase == TSF_PH_STOP) begin
        do_write = (s_q.count < cap);
      end
      s_d.buf0 = s_q.buf1;
      s_d.buf_cnt = s_q.buf_cnt - 2'h1;
    end
    if (do_write) begin
      s_d.wr_ptr = next_ptr(s_q.wr_ptr);
      if (overwrite) begin
        s_d.rd_ptr = next_ptr(s_q.rd_ptr);
      end else begin
        s_d.count = s_q.count + `TSF_CNT_W'(1);
      end
      s_d.status.overrun_flag = overwrite;
    end
    if (overwrite) begin
      s_d.status.overrun_sticky_flag = 1'b1;
    end else if (MODE_SELECT_I == `TSF_MODE_BYPASS) begin
      s_d.status.overrun_sticky_flag = 1'b0;
    end

    // skid buffer fill
    if (SAMPLE_VALID_I && SAMPLE_READY_O) begin
      if (s_d.buf_cnt == 2'h0) begin
        s_d.buf0 = SAMPLE_I;
      end else begin
        s_d.buf1 = SAMPLE_I;
      end
      s_d.buf_cnt = s_d.buf_cnt + 2'h1;
    end

    // idle keeps the store empty
    if (s_d.phase == TSF_PH_IDLE) begin
      s_d.wr_ptr = '0;
      s_d.rd_ptr = '0;
      s_d.count = `TSF_RST_COUNT;
      s_d.byte_idx = `TSF_TAG_BYTE;
      s_d.buf_cnt = 2'h0;
      s_d.status.overrun_flag = 1'b0;
    end

    s_d.status.stored_word_count = s_d.count;
    s_d.status.threshold_reached_flag = (s_d.count >= {1'b0, THRESHOLD_LEVEL_I});
    s_d.status.buffer_full_flag = (s_d.phase != TSF_PH_IDLE)
        && ({1'b0, s_d.count} + 11'h001 >= {1'b0, cap});
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_q <= '0;
      s_q.phase <= TSF_PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // sample storage has no reset; the count says what is valid
  always_ff @(posedge CLOCK_I) begin
    if (do_write) begin
      mem[s_q.wr_ptr] <= s_q.buf0;
    end
  end

  assign READ_BYTE_O = s_q.rd_byte;
  assign STATUS_O = s_q.status;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  property p_trig_to_stop;
    (MODE_SELECT_I == `TSF_MODE_CONT_TO_STOP) && (s_q.phase == TSF_PH_OVERWRITE) && evt_edge
    ##1 (MODE_SELECT_I == `TSF_MODE_CONT_TO_STOP) |-> s_q.phase == TSF_PH_STOP;
  endproperty
  a_trig_to_stop: assert property (p_trig_to_stop) else $error("trigger did not stop overwrite");

  property p_trig_held;
    s_q.trig && (MODE_SELECT_I != `TSF_MODE_BYPASS) |=> s_q.trig;
  endproperty
  a_trig_held: assert property (p_trig_held) else $error("trigger lost before bypass");

  property p_bypass_empty;
    (MODE_SELECT_I == `TSF_MODE_BYPASS) |=> (STATUS_O.stored_word_count == '0) && !STATUS_O.buffer_full_flag;
  endproperty
  a_bypass_empty: assert property (p_bypass_empty) else $error("bypass left words stored");

  property p_stop_holds;
    (s_q.phase == TSF_PH_STOP) && (s_q.count >= cap) && !pop && (s_d.phase != TSF_PH_IDLE)
    |=> s_q.count == $past(s_q.count);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("store grew after full");

  property p_overwrite;
    (s_q.phase == TSF_PH_OVERWRITE) && drain && (s_q.count >= cap) && (s_d.phase != TSF_PH_IDLE)
    |=> STATUS_O.overrun_flag && STATUS_O.overrun_sticky_flag && (s_q.count == $past(s_q.count));
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("overwrite not flagged");

  property p_pop;
    pop && (s_d.phase != TSF_PH_IDLE) |=> (s_q.count == $past(s_q.count) - 10'h001) && (s_q.byte_idx == 3'h0);
  endproperty
  a_pop: assert property (p_pop) else $error("finished word not freed");

  property p_wrap;
    BYTE_READ_I && !BURST_START_I && (s_q.byte_idx == 3'h6) && (s_d.phase != TSF_PH_IDLE)
    |=> s_q.byte_idx == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("byte index did not wrap");

  property p_threshold;
    1 |=> STATUS_O.threshold_reached_flag == (STATUS_O.stored_word_count >= {1'b0, $past(THRESHOLD_LEVEL_I)});
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold flag wrong");

  property p_full_flag;
    (s_q.phase != TSF_PH_IDLE) && (STATUS_O.stored_word_count + 10'h001 < cap) && $stable(cap)
    |-> !STATUS_O.buffer_full_flag;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag early");

  property p_ready;
    (s_q.buf_cnt == 2'h2) |-> !SAMPLE_READY_O ##1 (s_q.buf_cnt != 2'h3);
  endproperty
  a_ready: assert property (p_ready) else $error("buffer accepted while full");

  property p_idle_cont;
    (MODE_SELECT_I == `TSF_MODE_BYPASS_TO_CONT) && !s_d.trig |=> STATUS_O.stored_word_count == '0;
  endproperty
  a_idle_cont: assert property (p_idle_cont) else $error("store filled before trigger");

  property p_idle_stop;
    (MODE_SELECT_I == `TSF_MODE_BYPASS_TO_STOP) && !s_d.trig |=> STATUS_O.stored_word_count == '0;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("store filled before trigger");

  property p_trig_clear;
    (MODE_SELECT_I == `TSF_MODE_BYPASS) |=> !s_q.trig;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger survived bypass");

  property p_trig_armed;
    !s_q.trig && !(armed && evt_edge) |=> !s_q.trig;
  endproperty
  a_trig_armed: assert property (p_trig_armed) else $error("trigger without armed edge");

  property p_trig_route;
    !s_q.trig && !evt_now |=> !s_q.trig;
  endproperty
  a_trig_route: assert property (p_trig_route) else $error("trigger from unrouted source");

  property p_stop_no_write;
    (s_q.phase == TSF_PH_STOP) && (s_q.count >= cap) |-> !do_write;
  endproperty
  a_stop_no_write: assert property (p_stop_no_write) else $error("write into full store");

  property p_fill_on;
    (s_q.phase == TSF_PH_STOP) && drain && (s_q.count < cap) |-> do_write;
  endproperty
  a_fill_on: assert property (p_fill_on) else $error("sample dropped before full");

  property p_full_rise;
    (s_q.phase != TSF_PH_IDLE) && (STATUS_O.stored_word_count + 10'h001 >= cap) && $stable(cap)
    |-> STATUS_O.buffer_full_flag;
  endproperty
  a_full_rise: assert property (p_full_rise) else $error("full flag missing");

  property p_first_byte;
    BURST_START_I ##1 (BYTE_READ_I && !BURST_START_I) |=> READ_BYTE_O == $past(head.tag);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("burst did not start at tag");

  property p_count_bound;
    STATUS_O.stored_word_count <= DEPTH_CNT;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count above depth");

  property p_sticky_hold;
    STATUS_O.overrun_sticky_flag && (MODE_SELECT_I != `TSF_MODE_BYPASS) |=> STATUS_O.overrun_sticky_flag;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky overrun lost");

  property p_ovr_sticky;
    STATUS_O.overrun_flag |-> STATUS_O.overrun_sticky_flag;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun without sticky flag");

  c_trigger: cover property ((MODE_SELECT_I == `TSF_MODE_CONT_TO_STOP) && evt_edge);
  c_overwrite: cover property (overwrite);
  c_pop: cover property (pop);
  c_stall: cover property (SAMPLE_VALID_I && !SAMPLE_READY_O);
endmodule

// *** sim/tsf_host_model.sv ***
`timescale 1ns/1ps
module tsf_host_model (
  // clock
  input wire logic clock_i,
  // readout pins of the buffer
  input wire logic [7:0] read_byte_i,
  output logic burst_start_o,
  output logic byte_read_o
);
  import tsf_pkg::*;
  logic [55:0] got [0:7];
  initial begin
    burst_start_o = 1'b0;
    byte_read_o = 1'b0;
  end
  // whole words only, always from the tag byte; the device must wrap
  // the byte index between words, the host never restarts it
  task automatic read_burst(input int n);
    @(posedge clock_i) #1;
    burst_start_o = 1'b1;
    @(posedge clock_i) #1;
    burst_start_o = 1'b0;
    byte_read_o = 1'b1;
    for (int k = 0; k < 7 * n; k++) begin
      @(posedge clock_i) #1;
      got[k / 7][8 * (k % 7) +: 8] = read_byte_i;
    end
    byte_read_o = 1'b0;
  endtask
endmodule

// *** sim/triggered_sample_fifo_tb_top.sv ***
`timescale 1ns/1ps
`include "tsf_defines.svh"
module triggered_sample_fifo_tb_top;
  import tsf_pkg::*;
  logic clk, rst_n, stop_thr, sv, ff, wu, ori, rdy, bst, brd;
  logic [2:0] mode;
  logic [8:0] thr;
  logic [7:0] rbyte;
  tsf_route_t route;
  tsf_sample_t smp;
  tsf_status_t st;
  int err_count, n_checks, idx, b;
  // depth cut to 8 so the unlimited fill stays short
  tsf_triggered_fifo #(.DEPTH(8)) DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .MODE_SELECT_I(mode),
    .STOP_AT_THRESHOLD_I(stop_thr), .THRESHOLD_LEVEL_I(thr), .IRQ_B_ROUTING_CONFIG_I(route),
    .FREEFALL_EVENT_I(ff), .WAKEUP_EVENT_I(wu), .ORIENTATION_EVENT_I(ori), .SAMPLE_VALID_I(sv),
    .SAMPLE_I(smp), .SAMPLE_READY_O(rdy), .BURST_START_I(bst), .BYTE_READ_I(brd),
    .READ_BYTE_O(rbyte), .STATUS_O(st));
  tsf_host_model HOST (.clock_i(clk), .read_byte_i(rbyte), .burst_start_o(bst), .byte_read_o(brd));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [55:0] mk(input int i);
    return {{6{8'(i)}} ^ 48'h0a0b_0c0d_0e0f, 8'h10 + 8'(i)};
  endfunction
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic push(input int n);
    for (int k = 0; k < n; k++) begin
      sv = 1'b1;
      smp = mk(idx);
      idx++;
      for (int w = 0; w < 20 && rdy !== 1'b1; w++) @(posedge clk) #1;
      if (rdy !== 1'b1) begin
        err_count++;
        $display("ERROR %0t: sample never accepted", $time);
        stop_test();
      end
      @(posedge clk) #1;
    end
    sv = 1'b0;
    tick(6);
  endtask
  task automatic trig(input logic [2:0] e);
    {ff, wu, ori} = e;
    tick(1);
    {ff, wu, ori} = 3'h0;
    tick(2);
  endtask
  // the count is checked first so a short buffer is flagged as an error before the host reads it
  task automatic rd(input int n, input int first);
    if (st.stored_word_count < 10'(n)) chk(st.stored_word_count, 10'(n));
    HOST.read_burst(n);
    for (int k = 0; k < n; k++) chk(HOST.got[k], mk(first + k));
    tick(3);
  endtask
  task automatic cfg(input logic [2:0] m, input logic s, input logic [8:0] t, input logic [2:0] r);
    mode = `TSF_MODE_BYPASS;
    tick(3);
    chk(st, 14'h0000);
    stop_thr = s;
    thr = t;
    route = r;
    mode = m;
    tick(2);
  endtask
  // ----------------------------------------------------------------
  // clock and sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    mode = 3'h0;
    stop_thr = 1'b0;
    // a zero threshold would raise the threshold flag even while empty
    thr = 9'h004;
    route = 3'h0;
    {ff, wu, ori} = 3'h0;
    sv = 1'b0;
    smp = 56'h0;
    err_count = 0;
    n_checks = 0;
    idx = 0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(1);
    cfg(`TSF_MODE_STOP_FULL, 1'b1, 9'h004, 3'h0);
    b = idx;
    push(6);
    chk(st, {10'h004, 4'hc});
    rd(2, b);
    chk(st, {10'h002, 4'h0});
    cfg(`TSF_MODE_STOP_FULL, 1'b0, 9'h004, 3'h0);
    b = idx;
    push(2);
    // reads overlap the stream so that each freed word stalls the skid buffer once
    fork
      HOST.read_burst(2);
      begin
        tick(7);
        push(8);
      end
    join
    chk(HOST.got[0], mk(b));
    chk(HOST.got[1], mk(b + 1));
    chk(st, {10'h008, 4'hc});
    rd(8, b + 2);
    cfg(`TSF_MODE_STOP_FULL, 1'b0, 9'h003, 3'h0);
    push(2);
    chk(st, {10'h002, 4'h0});
    push(1);
    chk(st, {10'h003, 4'h8});
    push(6);
    chk(st, {10'h008, 4'hc});
    cfg(`TSF_MODE_CONTINUOUS, 1'b1, 9'h004, 3'h0);
    b = idx;
    push(6);
    chk(st, {10'h004, 4'hf});
    rd(4, b + 2);
    chk(st.stored_word_count, 10'h000);
    cfg(`TSF_MODE_BYPASS_TO_CONT, 1'b1, 9'h004, 3'b010);
    push(2);
    chk(st, 14'h0000);
    trig(3'b100);
    push(1);
    chk(st, 14'h0000);
    trig(3'b010);
    b = idx;
    push(6);
    chk(st, {10'h004, 4'hf});
    rd(4, b + 2);
    cfg(`TSF_MODE_BYPASS_TO_STOP, 1'b1, 9'h004, 3'b001);
    push(1);
    chk(st, 14'h0000);
    trig(3'b001);
    b = idx;
    push(6);
    chk(st, {10'h004, 4'hc});
    rd(4, b);
    cfg(`TSF_MODE_CONT_TO_STOP, 1'b1, 9'h004, 3'b100);
    b = idx;
    push(6);
    trig(3'b100);
    push(2);
    chk(st.stored_word_count, 10'h004);
    rd(4, b + 2);
    cfg(`TSF_MODE_CONT_TO_STOP, 1'b1, 9'h004, 3'b100);
    b = idx;
    push(2);
    trig(3'b100);
    trig(3'b100);
    push(4);
    chk(st.stored_word_count, 10'h004);
    rd(4, b);
    stop_test();
  end
endmodule
